/* hw/irq_cfg_pkg.sv */
// constants for the interrupt priority and enable block
//
// Contract
// RQ1: priority register bit 7 always reads 1, writes to it ignored.
// RQ2: priority bits 6..0 set levels for spi, t2, uart, t1, ext1, t0, ext0.
// RQ3: enable bit 7 passes timer three low or high overflow; cleared blocks both.
// RQ4: enable bit 5 gates comparator rise and fall requests.
// RQ5: enable bit 4 gates every counter array request.
// RQ6: enable bit 3 gates the conversion done request.
// RQ7: enable bit 2 gates the window compare request.
// RQ8: enable bit 0 gates every smbus request.
// RQ9: bits 6 and 1 of extended registers read 0; software writes 0.
// RQ10: extended priority bits 7,5,4,3,2,0 set levels of the six sources.
// RQ11: config bit 7 sets ext input one polarity, 1 active high.
// RQ12: config bits 6..4 pick the port zero pin for ext input one.
// RQ13: config bit 3 sets ext input zero polarity, 1 active high.
// RQ14: config bits 2..0 pick the port zero pin for ext input zero.
// RQ15: ext inputs sample pins without driving or disturbing them.
// RQ16: crossbar may not take a port zero pin whose skip bit is 1.
// RQ17: global gate at 0 blocks every request.
// RQ18: pending requests sampled and priority decoded every clock.
// RQ19: under equal or higher service, wait for return plus one instruction.
// RQ20: high preempts low; equal levels resolve by fixed source order.
package irq_cfg_pkg;
  // register indexes; byte address is four times the index
  localparam logic [7:0] IDX_ENABLE = 8'ha8;
  localparam logic [7:0] IDX_PRIO = 8'hb8;
  localparam logic [7:0] IDX_SKIP = 8'hd4;
  localparam logic [7:0] IDX_EXTCFG = 8'he4;
  localparam logic [7:0] IDX_EXT_EN = 8'hf6;
  localparam logic [7:0] IDX_EXT_PRIO = 8'hf7;
  localparam logic [7:0] IDX_STATUS = 8'hf8;
  // reset values
  localparam logic [7:0] RST_ENABLE = 8'h00;
  localparam logic [7:0] RST_PRIO = 8'h80;
  localparam logic [7:0] RST_SKIP = 8'h00;
  localparam logic [7:0] RST_EXTCFG = 8'h01;
  localparam logic [7:0] RST_EXT = 8'h00;
  // field positions
  localparam int PRIO_TOP = 7;
  localparam int GLOBAL_GATE = 7;
  localparam int EXT_ONE_POL = 7;
  localparam int EXT_ONE_SEL = 4;
  localparam int EXT_ZERO_POL = 3;
  localparam int EXT_ZERO_SEL = 0;
  localparam logic [7:0] EXT_WR_MASK = 8'hbd;
  // source numbers, in fixed natural order
  localparam int NSRC = 15;
  localparam logic [3:0] SRC_SMBUS = 4'h7;
  localparam logic [3:0] SRC_PCA = 4'hb;
  localparam logic [3:0] SRC_T3 = 4'he;
  typedef enum logic [0:0] {st_run, st_hold} svc_state_t;
endpackage : irq_cfg_pkg

/* hw/irq_priority_enable_extint.sv */
// interrupt enable, priority and external input configuration
`timescale 1ns/100ps
`default_nettype none
module irq_priority_enable_extint
  import irq_cfg_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] port_zero_pins,
  input wire logic timer0_flag,
  input wire logic timer1_flag,
  input wire logic uart_flag,
  input wire logic timer2_flag,
  input wire logic spi_flag,
  input wire logic smbus_flag,
  input wire logic window_compare_flag,
  input wire logic conversion_done_flag,
  input wire logic counter_array_flag,
  input wire logic comparator_rise_flag,
  input wire logic comparator_fall_flag,
  input wire logic timer_three_low_overflow,
  input wire logic timer_three_high_overflow,
  input wire logic vector_taken,
  input wire logic service_return,
  input wire logic instr_done,
  output logic irq_req,
  output logic [3:0] irq_source,
  output logic irq_high,
  output logic [7:0] crossbar_pin_allow
);

  // ************************************
  // helpers
  // ************************************

  // lowest set index wins, giving the fixed source order
  function automatic logic [4:0] first_set(input logic [NSRC-1:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction : first_set

  // ************************************
  // register file
  // ************************************

  logic [7:0] enable_ff, nxt_enable;
  logic [7:0] basic_priority_select_ff, nxt_prio;
  logic [7:0] port_zero_skip_ff, nxt_skip;
  logic [7:0] external_input_config_ff, nxt_cfg;
  logic [7:0] extended_enable_one_ff, nxt_ext_en;
  logic [7:0] extended_priority_one_ff, nxt_ext_prio;
  logic [31:0] prdata_ff, nxt_prdata;
  logic pready_ff, nxt_pready;
  logic pslverr_ff, nxt_pslverr;
  logic [7:0] idx;
  logic hit;
  logic [7:0] rd_val;
  logic wr_go;
  logic [7:0] status;
  logic in_low_ff, in_high_ff, nxt_in_low, nxt_in_high;
  svc_state_t state_ff, nxt_state;
  logic req_ff, nxt_req;
  logic [3:0] src_ff, nxt_src;
  logic high_ff, nxt_high;
  logic [7:0] allow_ff, nxt_allow;

  assign idx = paddr[9:2];
  assign wr_go = psel & penable & pready_ff & pwrite & hit;
  assign status = {in_high_ff, in_low_ff, state_ff == st_hold, req_ff, src_ff};

  // address decode and read mux
  always_comb begin
    hit = 1'b1;
    rd_val = 8'h00;
    if (paddr[11:10] != 2'b00 || paddr[1:0] != 2'b00) begin
      hit = 1'b0;
    end else begin
      case (idx)
        IDX_ENABLE: rd_val = enable_ff;
        IDX_PRIO: rd_val = basic_priority_select_ff;
        IDX_SKIP: rd_val = port_zero_skip_ff;
        IDX_EXTCFG: rd_val = external_input_config_ff;
        IDX_EXT_EN: rd_val = extended_enable_one_ff;
        IDX_EXT_PRIO: rd_val = extended_priority_one_ff;
        IDX_STATUS: rd_val = status;
        default: hit = 1'b0;
      endcase
    end
  end

  // write and answer; ready rises in the access phase, so no wait states
  always_comb begin
    nxt_enable = enable_ff;
    nxt_prio = basic_priority_select_ff;
    nxt_skip = port_zero_skip_ff;
    nxt_cfg = external_input_config_ff;
    nxt_ext_en = extended_enable_one_ff;
    nxt_ext_prio = extended_priority_one_ff;
    nxt_pready = psel & ~penable;
    nxt_prdata = prdata_ff;
    nxt_pslverr = pslverr_ff;
    if (psel & ~penable) begin
      nxt_prdata = {24'h000000, rd_val};
      nxt_pslverr = ~hit;
    end
    if (wr_go) begin
      case (idx)
        IDX_ENABLE: nxt_enable = pwdata[7:0];
        IDX_PRIO: nxt_prio = {1'b1, pwdata[6:0]}; // RQ1 RQ2
        IDX_SKIP: nxt_skip = pwdata[7:0];
        IDX_EXTCFG: nxt_cfg = pwdata[7:0];
        // reserved bits held at zero whatever is written
        IDX_EXT_EN: nxt_ext_en = pwdata[7:0] & EXT_WR_MASK; // RQ9
        IDX_EXT_PRIO: nxt_ext_prio = pwdata[7:0] & EXT_WR_MASK; // RQ9
        default: nxt_enable = enable_ff;
      endcase
    end
  end

  // register bank
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_ff <= RST_ENABLE;
      basic_priority_select_ff <= RST_PRIO;
      port_zero_skip_ff <= RST_SKIP;
      external_input_config_ff <= RST_EXTCFG;
      extended_enable_one_ff <= RST_EXT;
      extended_priority_one_ff <= RST_EXT;
      prdata_ff <= 32'h00000000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      enable_ff <= nxt_enable;
      basic_priority_select_ff <= nxt_prio;
      port_zero_skip_ff <= nxt_skip;
      external_input_config_ff <= nxt_cfg;
      extended_enable_one_ff <= nxt_ext_en;
      extended_priority_one_ff <= nxt_ext_prio;
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
    end
  end

  // ************************************
  // source gathering
  // ************************************

  logic [7:0] cfg;
  logic ext_zero_act, ext_one_act;
  logic [NSRC-1:0] flags, enables, levels, pend;
  assign cfg = external_input_config_ff;

  // pins are only read, never driven, so crossbar users are untouched
  always_comb begin
    ext_zero_act = port_zero_pins[cfg[EXT_ZERO_SEL+:3]]; // RQ14 RQ15
    ext_one_act = port_zero_pins[cfg[EXT_ONE_SEL+:3]]; // RQ12 RQ15
    if (!cfg[EXT_ZERO_POL]) begin
      ext_zero_act = ~ext_zero_act; // RQ13
    end
    if (!cfg[EXT_ONE_POL]) begin
      ext_one_act = ~ext_one_act; // RQ11
    end
  end

  // flags in source order; slots 8 and 13 are empty
  assign flags = {
    timer_three_low_overflow | timer_three_high_overflow, 1'b0,
    comparator_rise_flag | comparator_fall_flag, counter_array_flag,
    conversion_done_flag, window_compare_flag, 1'b0, smbus_flag,
    spi_flag, timer2_flag, uart_flag, timer1_flag, ext_one_act,
    timer0_flag, ext_zero_act};

  // per-source enables and levels
  always_comb begin
    enables = '0;
    levels = '0;
    enables[6:0] = enable_ff[6:0];
    levels[6:0] = basic_priority_select_ff[6:0]; // RQ2
    enables[14] = extended_enable_one_ff[7]; // RQ3
    enables[12] = extended_enable_one_ff[5]; // RQ4
    enables[11] = extended_enable_one_ff[4]; // RQ5
    enables[10] = extended_enable_one_ff[3]; // RQ6
    enables[9] = extended_enable_one_ff[2]; // RQ7
    enables[7] = extended_enable_one_ff[0]; // RQ8
    levels[14] = extended_priority_one_ff[7]; // RQ10
    levels[12] = extended_priority_one_ff[5]; // RQ10
    levels[11] = extended_priority_one_ff[4]; // RQ10
    levels[10] = extended_priority_one_ff[3]; // RQ10
    levels[9] = extended_priority_one_ff[2]; // RQ10
    levels[7] = extended_priority_one_ff[0]; // RQ10
  end

  // global gate overrides every individual enable
  assign pend = flags & enables & {NSRC{enable_ff[GLOBAL_GATE]}}; // RQ17

  // ************************************
  // service tracking and arbitration
  // ************************************

  logic [4:0] pick_hi, pick_lo;
  assign pick_hi = first_set(pend & levels); // RQ20
  assign pick_lo = first_set(pend & ~levels); // RQ20

  // decoded afresh every clock; ack drops the request the same edge
  always_comb begin
    nxt_state = state_ff;
    nxt_in_low = in_low_ff;
    nxt_in_high = in_high_ff;
    nxt_req = 1'b0;
    nxt_src = src_ff;
    nxt_high = high_ff;
    if (vector_taken && req_ff) begin
      if (high_ff) begin
        nxt_in_high = 1'b1;
      end else begin
        nxt_in_low = 1'b1;
      end
    end
    case (state_ff)
      st_run: begin
        if (service_return) begin
          // one instruction must run before the next vector
          nxt_state = st_hold; // RQ19
          if (in_high_ff) begin
            nxt_in_high = 1'b0;
          end else begin
            nxt_in_low = 1'b0;
          end
        end else if (!vector_taken && !in_high_ff) begin
          if (pick_hi[4]) begin
            nxt_req = 1'b1; // RQ18 RQ20
            nxt_src = pick_hi[3:0];
            nxt_high = 1'b1;
          end else if (pick_lo[4] && !in_low_ff) begin
            nxt_req = 1'b1; // RQ18 RQ19
            nxt_src = pick_lo[3:0];
            nxt_high = 1'b0;
          end
        end
      end
      st_hold: begin
        if (instr_done) begin
          nxt_state = st_run; // RQ19
        end
      end
      default: nxt_state = st_run;
    endcase
    nxt_allow = ~port_zero_skip_ff; // RQ16
  end

  // service state and outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= st_run;
      in_low_ff <= 1'b0;
      in_high_ff <= 1'b0;
      req_ff <= 1'b0;
      src_ff <= 4'h0;
      high_ff <= 1'b0;
      allow_ff <= 8'hff;
    end else begin
      state_ff <= nxt_state;
      in_low_ff <= nxt_in_low;
      in_high_ff <= nxt_in_high;
      req_ff <= nxt_req;
      src_ff <= nxt_src;
      high_ff <= nxt_high;
      allow_ff <= nxt_allow;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign irq_req = req_ff;
  assign irq_source = src_ff;
  assign irq_high = high_ff;
  assign crossbar_pin_allow = allow_ff;

  // ************************************
  // checks
  // ************************************

  a_prio_top_one: // RQ1
    assert property (@(posedge pclk) disable iff (!presetn)
      basic_priority_select_ff[PRIO_TOP])
    else $error("priority bit 7 not one");

  a_prio_write_low: // RQ2
    assert property (@(posedge pclk) disable iff (!presetn)
      (wr_go && idx == IDX_PRIO) |=> basic_priority_select_ff[6:0] == $past(pwdata[6:0]))
    else $error("priority write lost");

  a_ext_rsvd_zero: // RQ9
    assert property (@(posedge pclk) disable iff (!presetn)
      !extended_enable_one_ff[6] && !extended_enable_one_ff[1]
      && !extended_priority_one_ff[6] && !extended_priority_one_ff[1])
    else $error("reserved bit set");

  a_global_blocks: // RQ17
    assert property (@(posedge pclk) disable iff (!presetn)
      !enable_ff[GLOBAL_GATE] |=> !irq_req)
    else $error("request with global gate off");

  a_t3_gated: // RQ3
    assert property (@(posedge pclk) disable iff (!presetn)
      (irq_req && irq_source == SRC_T3) |-> $past(extended_enable_one_ff[7]))
    else $error("timer three passed while disabled");

  a_pca_gated: // RQ5
    assert property (@(posedge pclk) disable iff (!presetn)
      (irq_req && irq_source == SRC_PCA) |-> $past(extended_enable_one_ff[4]))
    else $error("counter array passed while disabled");

  a_smbus_gated: // RQ8
    assert property (@(posedge pclk) disable iff (!presetn)
      (irq_req && irq_source == SRC_SMBUS) |-> $past(extended_enable_one_ff[0]))
    else $error("smbus passed while disabled");

  a_decode_each_clock: // RQ18
    assert property (@(posedge pclk) disable iff (!presetn)
      (state_ff == st_run && !in_low_ff && !in_high_ff && |pend
       && !vector_taken && !service_return) |=> irq_req)
    else $error("pending request not raised");

  a_hold_after_return: // RQ19
    assert property (@(posedge pclk) disable iff (!presetn)
      (service_return && state_ff == st_run) |=> !irq_req ##0 state_ff == st_hold)
    else $error("request right after return");

  a_high_not_preempted: // RQ20
    assert property (@(posedge pclk) disable iff (!presetn)
      $past(in_high_ff) |-> !irq_req)
    else $error("request during high service");

  a_skip_pin_kept: // RQ16
    assert property (@(posedge pclk) disable iff (!presetn)
      ##1 (crossbar_pin_allow & $past(port_zero_skip_ff)) == 8'h00)
    else $error("skipped pin offered to crossbar");

endmodule : irq_priority_enable_extint
`default_nettype wire

/* tb/cpu_vector_model.sv */
// behavioural cpu side: takes vectors, runs nested service routines, returns
`timescale 1ns/100ps
`default_nettype none
module cpu_vector_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic take_en,
  input wire logic [7:0] svc_len,
  input wire logic irq_req,
  output logic vector_taken,
  output logic service_return,
  output logic instr_done,
  output logic [3:0] depth
);
  int left[$];
  // ****
  // vector, service and return sequencing
  // ****
  // one slot per nested routine; the innermost one always returns first
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vector_taken <= 1'b0;
      service_return <= 1'b0;
      instr_done <= 1'b0;
      depth <= 4'h0;
      left.delete();
    end else begin
      // request drops one edge after taking, so never take twice on it
      vector_taken <= take_en && irq_req && !vector_taken;
      instr_done <= service_return;
      service_return <= 1'b0;
      if (vector_taken) begin
        left.push_back(int'(svc_len));
      end else if (left.size() > 0) begin
        if (left[$] == 0) begin
          service_return <= 1'b1;
          left.pop_back();
        end else begin
          left[$] = left[$] - 1;
        end
      end
      depth <= 4'(left.size());
    end
  end
endmodule : cpu_vector_model
`default_nettype wire

/* tb/tb_irq_priority_enable_extint.sv */
// bench for register access, request gating and nested service
`timescale 1ns/100ps
`default_nettype none
module tb_irq_priority_enable_extint;
  import irq_cfg_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq_req, irq_high;
  logic take_en, vector_taken, service_return, instr_done, er, xr, xh;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] pins, svc_len, crossbar_pin_allow;
  logic [3:0] irq_source, depth, xs;
  logic [15:0] fl;
  logic [1:0] fl2;
  logic [7:0] rv [6];
  logic [7:0] idx [6];
  int fails, total_checks;

  irq_priority_enable_extint irq_priority_enable_extint_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port_zero_pins(pins), .timer0_flag(fl[1]), .timer1_flag(fl[3]), .uart_flag(fl[4]),
    .timer2_flag(fl[5]), .spi_flag(fl[6]), .smbus_flag(fl[7]), .window_compare_flag(fl[9]),
    .conversion_done_flag(fl[10]), .counter_array_flag(fl[11]),
    .comparator_rise_flag(fl[12]), .comparator_fall_flag(fl2[0]),
    .timer_three_low_overflow(fl[14]), .timer_three_high_overflow(fl2[1]),
    .vector_taken(vector_taken), .service_return(service_return), .instr_done(instr_done),
    .irq_req(irq_req), .irq_source(irq_source), .irq_high(irq_high),
    .crossbar_pin_allow(crossbar_pin_allow));

  cpu_vector_model cpu_vector_model_inst (
    .pclk(pclk), .presetn(presetn), .take_en(take_en), .svc_len(svc_len),
    .irq_req(irq_req), .vector_taken(vector_taken), .service_return(service_return),
    .instr_done(instr_done), .depth(depth));

  // ****
  // clock and watchdog
  // ****
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // whole run is about a thousand cycles; 30000 means a hang
  initial begin
    #300000;
    fails++;
    give_verdict();
  end

  // ****
  // tasks and reference model
  // ****
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    total_checks++;
    if (seen !== want) begin
      fails++;
      $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check

  // request held until pready is seen high at an edge; data taken there
  task automatic apb(input logic wr, input logic [7:0] ix, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'b00, ix, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    // read right at the edge, values are still the ones the slave sampled with
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    if (n == 20) fails++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic read_all();
    for (int r = 0; r < 6; r++) begin
      apb(1'b0, idx[r], 8'h00);
      check(rd, rv[r] | ((r == 1) ? 8'h80 : 8'h00));
    end
  endtask : read_all

  task automatic wait_depth(input int want);
    int n;
    n = 0;
    while (depth !== 4'(want) && n < 300) begin
      @(negedge pclk);
      n++;
    end
    check(n < 300, 1'b1);
  endtask : wait_depth

  // first high source wins, else first low; bit map skips the gate bit
  function automatic void expect_irq();
    logic [15:0] e, p;
    logic pd;
    int b;
    e = {rv[4], rv[0]};
    p = {rv[5], rv[1]};
    xr = 1'b0;
    xs = 4'h0;
    xh = 1'b0;
    for (int s = 0; s < 15; s++) begin
      b = (s < 7) ? s : s + 1;
      pd = (s == 0) ? (pins[rv[3][2:0]] == rv[3][3]) :
           (s == 2) ? (pins[rv[3][6:4]] == rv[3][7]) :
           (s == 12) ? (fl[12] | fl2[0]) : (s == 14) ? (fl[14] | fl2[1]) : fl[s];
      if (pd && e[b] && rv[0][7] && (!xr || (p[b] && !xh))) begin
        xr = 1'b1;
        xs = 4'(s);
        xh = p[b];
      end
    end
  endfunction : expect_irq

  // ****
  // main sequence
  // ****
  initial begin
    {psel, penable, pwrite, paddr, pwdata, take_en, fl, fl2, pins} = '0;
    svc_len = 8'h28;
    presetn = 1'b0;
    fails = 0;
    total_checks = 0;
    idx = '{IDX_ENABLE, IDX_PRIO, IDX_SKIP, IDX_EXTCFG, IDX_EXT_EN, IDX_EXT_PRIO};
    rv = '{RST_ENABLE, RST_PRIO, RST_SKIP, RST_EXTCFG, RST_EXT, RST_EXT};
    void'($urandom(32'h6995987d));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    check(crossbar_pin_allow, 8'hff);
    read_all();
    // random sweep of every register, flag and pin
    for (int i = 0; i < 40; i++) begin
      for (int r = 0; r < 6; r++) begin
        rv[r] = 8'($urandom());
        if (r > 3) rv[r] = rv[r] & 8'hbd;
        apb(1'b1, idx[r], rv[r]);
      end
      @(posedge pclk);
      fl <= 16'($urandom()) & 16'h5efa;
      fl2 <= 2'($urandom());
      pins <= 8'($urandom());
      repeat (2) @(posedge pclk);
      @(negedge pclk);
      expect_irq();
      check(irq_req, xr);
      if (xr) check(irq_source, xs);
      if (xr) check(irq_high, xh);
      check(crossbar_pin_allow, 8'(~rv[2]));
      if (i % 8 == 0) read_all();
    end
    // unmapped index is refused with an error and reads zero
    apb(1'b0, 8'h10, 8'h00);
    check({er, rd[30:0]}, 32'h80000000);
    // low service: equal level waits, high preempts, held request follows
    @(posedge pclk);
    fl <= 16'h0;
    fl2 <= 2'b00;
    apb(1'b1, IDX_EXT_EN, 8'h00);
    apb(1'b1, IDX_ENABLE, 8'h9a);
    apb(1'b1, IDX_PRIO, 8'h08);
    @(posedge pclk);
    fl <= 16'h0002;
    take_en <= 1'b1;
    wait_depth(1);
    @(posedge pclk);
    fl <= 16'h0010;
    repeat (10) begin
      @(negedge pclk);
      check(irq_req, 1'b0);
    end
    @(posedge pclk);
    fl <= 16'h0018;
    wait_depth(2);
    @(posedge pclk);
    fl <= 16'h0010;
    take_en <= 1'b0;
    wait_depth(0);
    for (int n = 0; n < 20 && irq_req !== 1'b1; n++) @(negedge pclk);
    check(irq_req, 1'b1);
    check(irq_source, 4'h4);
    check(irq_high, 1'b0);
    // status: no service active, run state, request up for the uart
    apb(1'b0, IDX_STATUS, 8'h00);
    check(rd, 32'h00000014);
    give_verdict();
  end
endmodule : tb_irq_priority_enable_extint
`default_nettype wire
